/* File: core/eil_encoder_index_latch.sv */
// encoder counter, index latch, switch latch and virtual stops
`timescale 1ns/1ps
module eil_encoder_index_latch
    import eil_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_n,
    input  wire logic        ref_left,
    input  wire logic        ref_right,
    input  wire logic [31:0] ramp_actual_position,
    output logic             stop_left,
    output logic             stop_right,
    output logic             virtual_stop_left,
    output logic             virtual_stop_right,
    output logic             index_event
);

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DONE = 2'b10
    } eil_rd_state_t;

    typedef struct packed {
        eil_rd_state_t          rd_state;
        logic [31:0]            rdata;
        logic [SWITCH_MODE_CONFIG_W-1:0]   switch_mode_config;
        logic [ENC_CFG_W-1:0]   enc_cfg;
        logic [31:0]            pos;
        logic [15:0]            frac;
        logic [31:0]            step_const;
        logic [31:0]            index_cap;
        logic [31:0]            latched_ramp_position;
        logic [DEV_LIMIT_W-1:0] dev_limit;
        logic [31:0]            lim_l;
        logic [31:0]            lim_r;
        logic                   n_event;
        logic                   dev_warn;
        logic                   latch_l;
        logic                   latch_r;
        logic                   once_armed;
        logic                   qual_prev;
        logic                   sw_l_act;
        logic                   sw_r_act;
        logic                   vstop_l;
        logic                   vstop_r;
        logic                   stop_l;
        logic                   stop_r;
        logic                   idx_pulse;
    } eil_state_t;

    eil_state_t s_reg;
    eil_state_t s_next;

    logic a_level;
    logic b_level;
    logic step;
    logic step_up;

    // ==========================================================
    // byte lane merge for register writes
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : be_merge

    eil_quad_decoder u_quad (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .enc_a   (enc_a),
        .enc_b   (enc_b),
        .a_level (a_level),
        .b_level (b_level),
        .step    (step),
        .step_up (step_up)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        logic [16:0] fsum;
        logic [16:0] modv;
        logic [31:0] istep;
        logic [31:0] sel_pos;
        logic [32:0] diff;
        logic [32:0] mag;
        logic [31:0] wd;
        logic [5:0]  idx;
        logic        carry;
        logic        n_act;
        logic        qual;
        logic        qual_evt;
        logic        do_cap;
        logic        l_raw;
        logic        r_raw;
        logic        l_act;
        logic        r_act;
        logic        l_evt;
        logic        r_evt;
        fsum     = '0;
        modv     = FRAC_MOD_BIN;
        istep    = '0;
        sel_pos  = '0;
        diff     = '0;
        mag      = '0;
        wd       = '0;
        idx      = avs_address[7:2];
        carry    = 1'b0;
        n_act    = 1'b0;
        qual     = 1'b0;
        qual_evt = 1'b0;
        do_cap   = 1'b0;
        l_raw    = 1'b0;
        r_raw    = 1'b0;
        l_act    = 1'b0;
        r_act    = 1'b0;
        l_evt    = 1'b0;
        r_evt    = 1'b0;
        s_next   = s_reg;
        s_next.idx_pulse = 1'b0;

        modv = s_reg.enc_cfg[CFG_DECIMAL] ? FRAC_MOD_DEC : FRAC_MOD_BIN;
        if (step)
        begin
            if (step_up)
            begin
                fsum = {1'b0, s_reg.frac} + {1'b0, s_reg.step_const[15:0]};
                if (fsum >= modv)
                begin
                    fsum  = fsum - modv;
                    carry = 1'b1;
                end
            end
            else
            begin
                fsum = {1'b0, s_reg.frac} - {1'b0, s_reg.step_const[15:0]};
                if (fsum[16])
                begin
                    fsum  = fsum + modv;
                    carry = 1'b1;
                end
            end
            istep = {{16{s_reg.step_const[31]}}, s_reg.step_const[31:16]}
                    + {31'h0000_0000, carry};
            s_next.pos  = step_up ? s_reg.pos + istep : s_reg.pos - istep;
            s_next.frac = fsum[15:0];
        end

        n_act = (enc_n == s_reg.enc_cfg[CFG_POL_N]);
        qual  = n_act & (s_reg.enc_cfg[CFG_IGNORE_QUADRATURE_LEVELS] |
                ((a_level == s_reg.enc_cfg[CFG_POL_A]) &&
                 (b_level == s_reg.enc_cfg[CFG_POL_B])));
        s_next.qual_prev = qual;
        case (s_reg.enc_cfg[CFG_EDGE_LO +: 2])
            EDGE_LEVEL: qual_evt = qual;
            EDGE_ACT:   qual_evt = qual & ~s_reg.qual_prev;
            EDGE_INACT: qual_evt = ~qual & s_reg.qual_prev;
            EDGE_BOTH:  qual_evt = qual ^ s_reg.qual_prev;
            default:    qual_evt = 1'b0;
        endcase

        do_cap = qual_evt & s_reg.enc_cfg[CFG_ALWAYS];
        if (qual_evt && s_reg.enc_cfg[CFG_ONCE] && s_reg.once_armed)
        begin
            do_cap            = 1'b1;
            s_next.once_armed = 1'b0;
        end
        if (do_cap)
        begin
            s_next.index_cap = s_reg.pos;
            if (s_reg.enc_cfg[CFG_CLEAR])
            begin
                s_next.pos  = '0;
                s_next.frac = '0;
            end
            if (s_reg.enc_cfg[CFG_LATCH_X])
                s_next.latched_ramp_position = ramp_actual_position;
        end

        // reference switches, swap then polarity
        l_raw = s_reg.switch_mode_config[SW_SWAP] ? ref_right : ref_left;
        r_raw = s_reg.switch_mode_config[SW_SWAP] ? ref_left : ref_right;
        l_act = l_raw ^ s_reg.switch_mode_config[SW_POL_L];
        r_act = r_raw ^ s_reg.switch_mode_config[SW_POL_R];
        s_next.sw_l_act = l_act;
        s_next.sw_r_act = r_act;
        l_evt = (s_reg.switch_mode_config[SW_LATCH_L_A] & l_act & ~s_reg.sw_l_act) |
                (s_reg.switch_mode_config[SW_LATCH_L_I] & ~l_act & s_reg.sw_l_act);
        r_evt = (s_reg.switch_mode_config[SW_LATCH_R_A] & r_act & ~s_reg.sw_r_act) |
                (s_reg.switch_mode_config[SW_LATCH_R_I] & ~r_act & s_reg.sw_r_act);
        if (l_evt || r_evt)
        begin
            s_next.latched_ramp_position = ramp_actual_position;
            if (s_reg.switch_mode_config[SW_LATCH_ENC])
                s_next.index_cap = s_reg.pos;
        end

        sel_pos = s_reg.switch_mode_config[SW_VSTOP_ENC] ? s_reg.pos : ramp_actual_position;
        s_next.vstop_l = $signed(sel_pos) <= $signed(s_reg.lim_l);
        s_next.vstop_r = $signed(sel_pos) >= $signed(s_reg.lim_r);
        s_next.stop_l  = (l_act & s_reg.switch_mode_config[SW_STOP_L_EN]) |
                         (s_next.vstop_l & s_reg.switch_mode_config[SW_VSTOP_L_EN]);
        s_next.stop_r  = (r_act & s_reg.switch_mode_config[SW_STOP_R_EN]) |
                         (s_next.vstop_r & s_reg.switch_mode_config[SW_VSTOP_R_EN]);

        diff = {s_reg.pos[31], s_reg.pos} -
               {ramp_actual_position[31], ramp_actual_position};
        mag  = diff[32] ? (33'h0_0000_0000 - diff) : diff;

        // ======================================================
        // register writes; hardware set beats software clear
        wd = avs_writedata;
        if (avs_write)
        begin
            if (idx == IDX_SWITCH_MODE)
                s_next.switch_mode_config = SWITCH_MODE_CONFIG_W'(be_merge({17'h0_0000, s_reg.switch_mode_config},
                                                     wd, avs_byteenable));
            else if (idx == IDX_SWITCH_STATUS && avs_byteenable[0])
            begin
                if (wd[ST_LATCH_L])
                    s_next.latch_l = 1'b0;
                if (wd[ST_LATCH_R])
                    s_next.latch_r = 1'b0;
            end
            else if (idx == IDX_ENC_CONFIG)
            begin
                s_next.enc_cfg    = ENC_CFG_W'(be_merge({21'h00_0000, s_reg.enc_cfg},
                                                        wd, avs_byteenable));
                s_next.once_armed = 1'b1;
            end
            else if (idx == IDX_ENC_COUNTER)
                s_next.pos = be_merge(s_next.pos, wd, avs_byteenable);
            else if (idx == IDX_STEP_CONST)
                s_next.step_const = be_merge(s_reg.step_const, wd, avs_byteenable);
            else if (idx == IDX_ENC_STATUS && avs_byteenable[0])
            begin
                if (wd[ES_INDEX])
                    s_next.n_event = 1'b0;
                if (wd[ES_DEV])
                    s_next.dev_warn = 1'b0;
            end
            else if (idx == IDX_DEV_LIMIT)
                s_next.dev_limit = DEV_LIMIT_W'(be_merge({12'h000, s_reg.dev_limit},
                                                         wd, avs_byteenable));
            else if (idx == IDX_LEFT_LIMIT)
                s_next.lim_l = be_merge(s_reg.lim_l, wd, avs_byteenable);
            else if (idx == IDX_RIGHT_LIMIT)
                s_next.lim_r = be_merge(s_reg.lim_r, wd, avs_byteenable);
        end

        // latch ready set on left or right event
        if (l_evt)
            s_next.latch_l = 1'b1;
        if (r_evt)
            s_next.latch_r = 1'b1;
        if (qual_evt)
        begin
            s_next.n_event   = 1'b1;
            s_next.idx_pulse = 1'b1;
        end
        if (s_reg.dev_limit != '0 && mag > {13'h0000, s_reg.dev_limit})
            s_next.dev_warn = 1'b1;

        // ======================================================
        // read: one wait state, data registered
        case (s_reg.rd_state)
            RD_IDLE:
            begin
                if (avs_read)
                begin
                    s_next.rd_state = RD_DONE;
                    if (idx == IDX_SWITCH_MODE)
                        s_next.rdata = {17'h0_0000, s_reg.switch_mode_config};
                    else if (idx == IDX_SWITCH_STATUS)
                        s_next.rdata = {16'h0000, s_reg.vstop_r, s_reg.vstop_l,
                                        10'h000, s_reg.latch_r, s_reg.latch_l,
                                        s_reg.sw_r_act, s_reg.sw_l_act};
                    else if (idx == IDX_RAMP_CAPTURE)
                        s_next.rdata = s_reg.latched_ramp_position;
                    else if (idx == IDX_ENC_CONFIG)
                        s_next.rdata = {21'h00_0000, s_reg.enc_cfg};
                    else if (idx == IDX_ENC_COUNTER)
                        s_next.rdata = s_reg.pos;
                    else if (idx == IDX_STEP_CONST)
                        s_next.rdata = s_reg.step_const;
                    else if (idx == IDX_ENC_STATUS)
                        s_next.rdata = {30'h0000_0000, s_reg.dev_warn, s_reg.n_event};
                    else if (idx == IDX_INDEX_CAPTURE)
                        s_next.rdata = s_reg.index_cap;
                    else if (idx == IDX_DEV_LIMIT)
                        s_next.rdata = {12'h000, s_reg.dev_limit};
                    else if (idx == IDX_LEFT_LIMIT)
                        s_next.rdata = s_reg.lim_l;
                    else if (idx == IDX_RIGHT_LIMIT)
                        s_next.rdata = s_reg.lim_r;
                    else
                        s_next.rdata = ZERO_RESET;
                end
            end
            default:
            begin
                s_next.rd_state = RD_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_reg            <= '0;
            s_reg.rd_state   <= RD_IDLE;
            s_reg.step_const <= STEP_CONST_RESET;
        end
        else
            s_reg <= s_next;
    end

    // reads stall one cycle; writes complete at once
    assign avs_waitrequest    = avs_read & (s_reg.rd_state == RD_IDLE);
    assign avs_readdata       = s_reg.rdata;
    assign stop_left          = s_reg.stop_l;
    assign stop_right         = s_reg.stop_r;
    assign virtual_stop_left  = s_reg.vstop_l;
    assign virtual_stop_right = s_reg.vstop_r;
    assign index_event        = s_reg.idx_pulse;

endmodule : eil_encoder_index_latch

/* File: core/eil_pkg.sv */
// constants and register map of the encoder index latch unit
package eil_pkg;

    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SWITCH_MODE   = 6'h34;
    localparam logic [5:0] IDX_SWITCH_STATUS = 6'h35;
    localparam logic [5:0] IDX_RAMP_CAPTURE  = 6'h36;
    localparam logic [5:0] IDX_ENC_CONFIG    = 6'h38;
    localparam logic [5:0] IDX_ENC_COUNTER   = 6'h39;
    localparam logic [5:0] IDX_STEP_CONST    = 6'h3A;
    localparam logic [5:0] IDX_ENC_STATUS    = 6'h3B;
    localparam logic [5:0] IDX_INDEX_CAPTURE = 6'h3C;
    localparam logic [5:0] IDX_DEV_LIMIT     = 6'h3D;
    localparam logic [5:0] IDX_LEFT_LIMIT    = 6'h3E;
    localparam logic [5:0] IDX_RIGHT_LIMIT   = 6'h3F;

    // ==========================================================
    // reset values
    localparam logic [31:0] STEP_CONST_RESET = 32'h0001_0000;
    localparam logic [31:0] ZERO_RESET       = 32'h0000_0000;

    // ==========================================================
    // encoder_config fields
    localparam int ENC_CFG_W     = 11;
    localparam int CFG_POL_A     = 0;
    localparam int CFG_POL_B     = 1;
    localparam int CFG_POL_N     = 2;
    localparam int CFG_IGNORE_QUADRATURE_LEVELS = 3;
    localparam int CFG_ALWAYS    = 4;
    localparam int CFG_ONCE      = 5;
    localparam int CFG_EDGE_LO   = 6;
    localparam int CFG_CLEAR     = 8;
    localparam int CFG_LATCH_X   = 9;
    localparam int CFG_DECIMAL   = 10;

    // index edge select codes
    localparam logic [1:0] EDGE_LEVEL = 2'h0;
    localparam logic [1:0] EDGE_ACT   = 2'h1;
    localparam logic [1:0] EDGE_INACT = 2'h2;
    localparam logic [1:0] EDGE_BOTH  = 2'h3;

    // ==========================================================
    // switch_mode_config fields
    localparam int SWITCH_MODE_CONFIG_W     = 15;
    localparam int SW_STOP_L_EN  = 0;
    localparam int SW_STOP_R_EN  = 1;
    localparam int SW_POL_L      = 2;
    localparam int SW_POL_R      = 3;
    localparam int SW_SWAP       = 4;
    localparam int SW_LATCH_L_A  = 5;
    localparam int SW_LATCH_L_I  = 6;
    localparam int SW_LATCH_R_A  = 7;
    localparam int SW_LATCH_R_I  = 8;
    localparam int SW_LATCH_ENC  = 9;
    localparam int SW_VSTOP_L_EN = 12;
    localparam int SW_VSTOP_R_EN = 13;
    localparam int SW_VSTOP_ENC  = 14;

    // ==========================================================
    // status bit positions
    localparam int ST_STOP_L  = 0;
    localparam int ST_STOP_R  = 1;
    localparam int ST_LATCH_L = 2;
    localparam int ST_LATCH_R = 3;
    localparam int ST_VSTOP_L = 14;
    localparam int ST_VSTOP_R = 15;
    localparam int ES_INDEX   = 0;
    localparam int ES_DEV     = 1;

    // ==========================================================
    // fraction moduli
    localparam logic [16:0] FRAC_MOD_BIN = 17'h1_0000;
    localparam logic [16:0] FRAC_MOD_DEC = 17'h0_2710;
    localparam int DEV_LIMIT_W = 20;

endpackage : eil_pkg

/* File: core/eil_quad_decoder.sv */
// quadrature decoder producing step pulses and direction
`timescale 1ns/1ps
module eil_quad_decoder
    import eil_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic enc_a,
    input  wire logic enc_b,
    output logic      a_level,
    output logic      b_level,
    output logic      step,
    output logic      step_up
);

    typedef struct packed {
        logic a;
        logic b;
        logic step;
        logic up;
    } eil_qd_state_t;

    eil_qd_state_t s_reg;
    eil_qd_state_t s_next;

    // ==========================================================
    // gray transitions; illegal double jumps are dropped
    always_comb
    begin
        s_next      = s_reg;
        s_next.a    = enc_a;
        s_next.b    = enc_b;
        s_next.step = 1'b0;
        case ({s_reg.a, s_reg.b, enc_a, enc_b})
            4'b0010, 4'b1011, 4'b1101, 4'b0100:
            begin
                s_next.step = 1'b1;
                s_next.up   = 1'b1;
            end
            4'b0001, 4'b0111, 4'b1110, 4'b1000:
            begin
                s_next.step = 1'b1;
                s_next.up   = 1'b0;
            end
            default:
            begin
                s_next.step = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign a_level = s_reg.a;
    assign b_level = s_reg.b;
    assign step    = s_reg.step;
    assign step_up = s_reg.up;

endmodule : eil_quad_decoder

/* File: tb/eil_assertions.sv */
// checker bound to the encoder index latch unit
`timescale 1ns/1ps
module eil_checker
    import eil_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] ramp_actual_position,
    input wire logic        stop_left,
    input wire logic        virtual_stop_left,
    input wire logic        virtual_stop_right,
    input wire logic        index_event
);
    // ==================
    // shadow of written setup; full byte lanes assumed
    logic [31:0] cfg_reg, smc_reg, lim_l_reg, lim_r_reg;
    always_ff @(posedge ref_clk)
        if (sys_rst)
            {cfg_reg, smc_reg, lim_l_reg, lim_r_reg} <= '0;
        else if (avs_write)
            case (avs_address[7:2])
                IDX_ENC_CONFIG:  cfg_reg <= avs_writedata;
                IDX_SWITCH_MODE: smc_reg <= avs_writedata;
                IDX_LEFT_LIMIT:  lim_l_reg <= avs_writedata;
                IDX_RIGHT_LIMIT: lim_r_reg <= avs_writedata;
                default:         ;
            endcase
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==================
    // properties
    a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered with no wait");
    a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read wait longer than one cycle");
    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address[7:2] == 6'h37 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_vstop_left: assert property (!smc_reg[SW_VSTOP_ENC] |=> virtual_stop_left ==
        ($signed($past(ramp_actual_position)) <= $signed($past(lim_l_reg))))
        else $error("left virtual stop wrong");
    a_vstop_right: assert property (!smc_reg[SW_VSTOP_ENC] |=> virtual_stop_right ==
        ($signed($past(ramp_actual_position)) >= $signed($past(lim_r_reg))))
        else $error("right virtual stop wrong");
    a_stop_quiet: assert property (!smc_reg[SW_STOP_L_EN] && !smc_reg[SW_VSTOP_L_EN]
        |=> !stop_left)
        else $error("left stop while disabled");
    a_idx_single: assert property (index_event && cfg_reg[7] != cfg_reg[6]
        |=> !index_event)
        else $error("edge index event longer than a cycle");
endmodule : eil_checker

bind eil_encoder_index_latch eil_checker u_eil_checker (.ref_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .ramp_actual_position, .stop_left, .virtual_stop_left, .virtual_stop_right, .index_event);

/* File: tb/eil_enc_model.sv */
// quadrature encoder with index channel, stepped on command
`timescale 1ns/1ps
module eil_enc_model
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic step_req,
    input  wire logic step_up,
    input  wire logic index_req,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_n
);
    // ==================
    // gray phase; one line changes per step
    logic [1:0] phase_reg;
    always_ff @(posedge ref_clk)
        if (sys_rst)
            phase_reg <= 2'h0;
        else if (step_req)
            phase_reg <= step_up ? phase_reg + 2'h1 : phase_reg - 2'h1;
    always_ff @(posedge ref_clk)
        enc_n <= !sys_rst && index_req;
    assign enc_a = phase_reg[1] ^ phase_reg[0];
    assign enc_b = phase_reg[1];
endmodule : eil_enc_model

/* File: tb/tb.sv */
// self-checking bench for the encoder index latch unit
`timescale 1ns/1ps
module tb
    import eil_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] ramp_actual_position = 32'h0;
    logic        ref_left = 1'b0;
    logic        step_req = 1'b0;
    logic        step_up = 1'b0;
    logic        index_req = 1'b0;
    logic        avs_waitrequest, enc_a, enc_b, enc_n, index_event;
    logic        stop_left, stop_right, virtual_stop_left, virtual_stop_right;
    logic [31:0] avs_readdata, r, v, lim_l, lim_r;
    int          pos, errors = 0, num_checks = 0, cyc = 0;
    logic [5:0]  idx_tab [8] = '{IDX_ENC_CONFIG, IDX_ENC_COUNTER, IDX_STEP_CONST,
        IDX_RIGHT_LIMIT, IDX_INDEX_CAPTURE, IDX_DEV_LIMIT, IDX_LEFT_LIMIT, 6'h37};
    always #50 ref_clk = ~ref_clk;
    eil_encoder_index_latch u_eil_encoder_index_latch (.ref_clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .enc_a, .enc_b, .enc_n, .ref_left, .ref_right(1'b0),
        .ramp_actual_position, .stop_left, .stop_right, .virtual_stop_left,
        .virtual_stop_right, .index_event);
    eil_enc_model u_eil_enc_model (.ref_clk, .sys_rst, .step_req, .step_up, .index_req,
        .enc_a, .enc_b, .enc_n);
    // ==================
    // bus, stimulus and compare tasks
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        avs_address <= {idx, 2'h0};
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        ck(r, exp);
    endtask : rc
    // held one cycle apart so every step is a separate edge
    task automatic steps(input int n, input logic up);
        repeat (n)
        begin
            step_req <= 1'b1;
            step_up <= up;
            @(posedge ref_clk);
            step_req <= 1'b0;
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask : steps
    task automatic pulse_n(input logic [31:0] cfg);
        bus(1'b1, IDX_ENC_CONFIG, cfg);
        bus(1'b1, IDX_ENC_STATUS, 32'h1);
        index_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        index_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse_n
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    // ==================
    // hang guard, well beyond the few hundred cycles needed
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    // ==================
    // main sequence
    initial
    begin
        v = $urandom(32'h04D9);
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        foreach (idx_tab[i])
            rc(idx_tab[i], idx_tab[i] == IDX_STEP_CONST ? STEP_CONST_RESET : ZERO_RESET);
        rc(IDX_ENC_STATUS, 32'h1);
        $display("test reset done");
        pos = $urandom;
        bus(1'b1, IDX_ENC_COUNTER, pos);
        rc(IDX_ENC_COUNTER, pos);
        steps(5, 1'b1);
        steps(2, 1'b0);
        pos += 3;
        rc(IDX_ENC_COUNTER, pos);
        bus(1'b1, IDX_STEP_CONST, 32'hFFFE_0000);
        steps(3, 1'b1);
        pos -= 6;
        rc(IDX_ENC_COUNTER, pos);
        $display("test counting done");
        v = $urandom;
        ramp_actual_position <= v;
        pulse_n(32'h0000_035C);
        rc(IDX_INDEX_CAPTURE, pos);
        rc(IDX_ENC_COUNTER, 32'h0);
        rc(IDX_RAMP_CAPTURE, v);
        rc(IDX_ENC_STATUS, 32'h1);
        bus(1'b1, IDX_ENC_STATUS, 32'h1);
        rc(IDX_ENC_STATUS, 32'h0);
        bus(1'b1, IDX_STEP_CONST, 32'h0000_8000);
        steps(4, 1'b1);
        rc(IDX_ENC_COUNTER, 32'h2);
        bus(1'b1, IDX_ENC_CONFIG, 32'h0000_0400);
        bus(1'b1, IDX_STEP_CONST, 32'h0000_1388);
        steps(4, 1'b1);
        rc(IDX_ENC_COUNTER, 32'h4);
        $display("test index and fraction done");
        for (int e = 0; e < 4; e++)
        begin
            pulse_n(32'(e << 6) | 32'h1C);
            rc(IDX_ENC_STATUS, 32'h1);
            rc(IDX_INDEX_CAPTURE, 32'h4);
        end
        for (int m = 0; m < 2; m++)
        begin
            pulse_n(32'h44 | {30'h0, enc_b ^ m[0], enc_a ^ m[0]});
            rc(IDX_ENC_STATUS, {31'h0, ~m[0]});
        end
        bus(1'b1, IDX_ENC_CONFIG, 32'h0000_006C);
        for (int k = 0; k < 2; k++)
        begin
            v = $urandom;
            bus(1'b1, IDX_ENC_COUNTER, v);
            if (k == 0)
                pos = v;
            index_req <= 1'b1;
            repeat (4) @(posedge ref_clk);
            index_req <= 1'b0;
            repeat (4) @(posedge ref_clk);
            rc(IDX_INDEX_CAPTURE, pos);
            rc(IDX_ENC_COUNTER, v);
        end
        $display("test index modes done");
        v = $urandom;
        ramp_actual_position <= v;
        bus(1'b1, IDX_SWITCH_MODE, 32'h21);
        ref_left <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rc(IDX_RAMP_CAPTURE, v);
        bus(1'b0, IDX_SWITCH_STATUS, 32'h0);
        ck(r & 32'hF, 32'h5);
        ck({30'h0, stop_right, stop_left}, 32'h1);
        bus(1'b1, IDX_SWITCH_STATUS, 32'h4);
        bus(1'b0, IDX_SWITCH_STATUS, 32'h0);
        ck(r & 32'hF, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            lim_l = $urandom;
            lim_r = $urandom;
            v = $urandom;
            ramp_actual_position <= v;
            bus(1'b1, IDX_LEFT_LIMIT, lim_l);
            bus(1'b1, IDX_RIGHT_LIMIT, lim_r);
            @(posedge ref_clk);
            ck({31'h0, virtual_stop_left}, {31'h0, $signed(v) <= $signed(lim_l)});
            ck({31'h0, virtual_stop_right}, {31'h0, $signed(v) >= $signed(lim_r)});
        end
        $display("test switches done");
        bus(1'b1, IDX_ENC_COUNTER, 32'h0);
        ramp_actual_position <= 32'h5;
        bus(1'b1, IDX_DEV_LIMIT, 32'h5);
        bus(1'b1, IDX_ENC_STATUS, 32'h3);
        rc(IDX_ENC_STATUS, 32'h0);
        ramp_actual_position <= 32'h6;
        repeat (3) @(posedge ref_clk);
        rc(IDX_ENC_STATUS, 32'h2);
        $display("test deviation done");
        final_report();
    end
endmodule : tb
